// [adc_path_pkg.sv]
// package: register map, field positions, reset values and ramp timing
// of the capture path control bank.
// assumes: an apb slave with 32-bit data, one register per aligned word.
package adc_path_pkg;
  // ----------------------------------------------------------------
  // register indexes (printed offsets) and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] idx_pair01 = 12'h01d; // pair 0/1 control index
  localparam logic [11:0] idx_pair23 = 12'h01e; // pair 2/3 control index
  localparam logic [11:0] idx_gain0 = 12'h01f; // channel 0 gain index
  localparam logic [11:0] idx_status = 12'h040; // filter enables and ramp state
  localparam logic [11:0] addr_pair01 = 12'(idx_pair01 * 4);
  localparam logic [11:0] addr_pair23 = 12'(idx_pair23 * 4);
  localparam logic [11:0] addr_gain0 = 12'(idx_gain0 * 4);
  localparam logic [11:0] addr_status = 12'(idx_status * 4);
  // ----------------------------------------------------------------
  // pair control fields
  // ----------------------------------------------------------------
  localparam int bit_en_lo = 0; // first converter enable
  localparam int bit_en_hi = 1; // second converter enable
  localparam int bit_src = 2; // decimator source select
  localparam int bit_swap = 3; // mic edge swap
  localparam int bit_pol = 4; // mic polarity
  localparam int bit_hp_lo = 5; // high-pass field low bit
  localparam int bit_hp_hi = 6; // high-pass field high bit
  localparam logic [7:0] pair_writable = 8'h7f; // bit 7 reserved, reads zero
  localparam logic [7:0] rst_pair = 8'h00;
  localparam logic [7:0] rst_gain = 8'h00;
  localparam logic [7:0] rst_filter = 8'h00; // all decimation filters off
  localparam logic [7:0] rst_mute = 8'h0f; // mutes set from reset
  // ----------------------------------------------------------------
  // gain ramp
  // ----------------------------------------------------------------
  localparam logic [7:0] gain_floor = 8'hff; // code of -95.625 dB
  localparam logic [7:0] gain_unity = 8'h00; // code of 0 dB
  localparam int samples_per_step = 16; // sample periods per ramp step
  localparam int ramp_steps = 256; // codes across full range
  // high-pass corner codes
  localparam logic [1:0] hp_off = 2'h0;
  localparam logic [1:0] hp_1hz = 2'h1;
  localparam logic [1:0] hp_4hz = 2'h2;
  localparam logic [1:0] hp_8hz = 2'h3;
endpackage : adc_path_pkg

// [gain_ramp.sv]
// gain_ramp: walks the applied gain code of one channel toward a target,
// one code per step, a step every 16 sample strobes.
// assumes: fs_tick is a one-cycle pulse from logic on pclk.
`timescale 1ns/1ps
module gain_ramp (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fs_tick, // one pulse per sample period
  input wire logic filter_on, // decimation filter enable
  input wire logic mute, // force full attenuation
  input wire logic bypass, // gain stage bypassed
  input wire logic [7:0] target, // programmed gain code
  output logic [7:0] applied, // gain code in use
  output logic ramping // ramp code differs from goal, with filter on and not bypassed
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code; // current code
    logic [3:0] div; // sample counter inside a step
    logic on_d; // previous filter enable
  } ramp_state_type;
  ramp_state_type cur_ff, nxt_cur;
  logic [7:0] goal; // where the ramp heads
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_cur = cur_ff;
    // mute means full attenuation, unless the stage is bypassed
    goal = (mute && !bypass) ? adc_path_pkg::gain_floor : target;
    nxt_cur.on_d = filter_on;
    if (!filter_on) begin
      nxt_cur.code = adc_path_pkg::gain_floor; // held at floor while off
      nxt_cur.div = 4'h0;
    end else if (!cur_ff.on_d) begin
      nxt_cur.code = adc_path_pkg::gain_floor; // ramp starts at -95.625 dB
      nxt_cur.div = 4'h0;
    end else if (fs_tick) begin
      nxt_cur.div = cur_ff.div + 4'h1;
      if (cur_ff.div == 4'(adc_path_pkg::samples_per_step - 1)) begin
        if (cur_ff.code > goal) nxt_cur.code = cur_ff.code - 8'h01;
        else if (cur_ff.code < goal) nxt_cur.code = cur_ff.code + 8'h01;
      end
    end
  end
  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cur_ff <= '{code: adc_path_pkg::gain_floor, div: 4'h0, on_d: 1'b0};
    else cur_ff <= nxt_cur;
  end
  // bypass applies the unity code gain_unity in place of the ramp code, no attenuation applied
  assign applied = bypass ? adc_path_pkg::gain_unity : cur_ff.code;
  assign ramping = filter_on && !bypass && (cur_ff.code != goal);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ramp_start_floor: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(filter_on) |=> ##1 (cur_ff.code == 8'hff))
    else $error("ramp did not start at floor");
  a_step_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_on && $past(filter_on) && cur_ff.code != $past(cur_ff.code))
      |-> $past(fs_tick) && $past(cur_ff.div) == 4'hf)
    else $error("gain step off the 16 sample grid");
  a_step_size: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_on && $past(filter_on) && $past(cur_ff.on_d))
      |-> (cur_ff.code - $past(cur_ff.code) inside {8'h00, 8'h01, 8'hff}))
    else $error("gain moved more than one code");
  a_mute_goal: assert property (@(posedge pclk) disable iff (!presetn)
    (mute && !bypass) |-> goal == 8'hff)
    else $error("mute did not target full attenuation");
  c_ramp_done: cover property (@(posedge pclk) disable iff (!presetn)
    filter_on && $fell(ramping));
endmodule : gain_ramp

// [adc_path_control_regs.sv]
// adc_path_control_regs: apb register bank of the four-channel capture
// path: source, mic polarity and swap, high-pass corner, converter
// enables, channel 0 gain with its soft ramp.
// assumes: single pclk domain; fs_tick comes from logic on pclk.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
// Functional notes
// - polarity bit 4 sets mic one-bit sign
// - swap bit 3 exchanges rising/falling edge channels
// - bit 2 picks converters or digital mics
// - converter on needs enable bit and filter
// - filter enable starts gain ramp from floor
// - one ramp step every 16 sample periods
// - gain code step 0.375 dB attenuation
// - mute forces full attenuation unless bypassed
module adc_path_control_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fs_tick, // sample strobe on pclk
  input wire logic [3:0] decim_filter_on, // ch0..ch3 decimation filter enables
  input wire logic [1:0] ch01_mute, // mute of channels 0 and 1
  input wire logic gain_bypass, // channel 0 gain stage bypassed
  output logic pair01_source_sel,
  output logic pair23_source_sel,
  output logic mic_pair_a_polarity,
  output logic mic_pair_b_polarity,
  output logic [1:0] mic_a_rise_chan, // 0 left, 1 right on rising edge
  output logic [1:0] mic_b_rise_chan,
  output logic mic_a_one_negative, // a one bit is a negative value
  output logic mic_b_one_negative,
  output logic mic_pair_a_swap,
  output logic mic_pair_b_swap,
  output logic [1:0] pair01_highpass_sel,
  output logic [1:0] pair23_highpass_sel,
  output logic [3:0] conv_running, // converter fully enabled
  output logic [7:0] ch0_gain_code // gain code in use on channel 0
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pair01; // pair 0/1 control
    logic [7:0] pair23; // pair 2/3 control
    logic [7:0] gain0; // programmed channel 0 gain
    logic [31:0] rdata; // registered read data
    logic ready; // access phase answer
    logic err; // unmapped address
    logic [3:0] filt_s; // filter enables, registered
    logic [3:0] run; // converter running
    logic [7:0] gain_out; // applied gain
    logic ramp; // ramp in progress
    // the inverted polarity flags get their own flops so that every
    // output of the bank leaves a register, not a gate after one
    logic neg_a; // pair a: a one bit is negative
    logic neg_b; // pair b: a one bit is negative
  } regs_state_type;
  regs_state_type st_ff, nxt_st;
  logic [7:0] applied; // from ramp engine
  logic ramping; // from ramp engine
  logic hit; // address decodes
  logic [3:0] en_mask; // enable bits of the four converters, masked by their filter enables
  // ----------------------------------------------------------------
  // channel 0 gain ramp
  // ----------------------------------------------------------------
  gain_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .fs_tick(fs_tick),
    .filter_on(st_ff.filt_s[0]),
    .mute(ch01_mute[0]),
    .bypass(gain_bypass),
    .target(st_ff.gain0),
    .applied(applied),
    .ramping(ramping)
  );
  // ----------------------------------------------------------------
  // bus and control next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    en_mask = 4'h0;
    hit = (paddr == adc_path_pkg::addr_pair01) || (paddr == adc_path_pkg::addr_pair23)
       || (paddr == adc_path_pkg::addr_gain0) || (paddr == adc_path_pkg::addr_status);
    // one wait state: answer in the second access cycle
    nxt_st.ready = psel && penable && !st_ff.ready;
    nxt_st.err = psel && penable && !st_ff.ready && !hit;
    if (psel && penable && !st_ff.ready) begin
      nxt_st.rdata = 32'h0;
      if (!pwrite) begin
        case (paddr)
          adc_path_pkg::addr_pair01: nxt_st.rdata = {24'h0, st_ff.pair01};
          adc_path_pkg::addr_pair23: nxt_st.rdata = {24'h0, st_ff.pair23};
          adc_path_pkg::addr_gain0: nxt_st.rdata = {24'h0, st_ff.gain0};
          adc_path_pkg::addr_status: nxt_st.rdata = {15'h0, st_ff.ramp, st_ff.gain_out,
                                                     st_ff.run, st_ff.filt_s};
          default: nxt_st.rdata = 32'h0;
        endcase
      end
    end
    // writes land at the edge where the slave answers ready
    if (psel && penable && pwrite && st_ff.ready) begin
      case (paddr)
        adc_path_pkg::addr_pair01: nxt_st.pair01 = pwdata[7:0] & adc_path_pkg::pair_writable;
        adc_path_pkg::addr_pair23: nxt_st.pair23 = pwdata[7:0] & adc_path_pkg::pair_writable;
        adc_path_pkg::addr_gain0: nxt_st.gain0 = pwdata[7:0];
        default: ;
      endcase
    end
    nxt_st.filt_s = decim_filter_on;
    // a channel runs only with both its enable and its filter set
    en_mask = {st_ff.pair23[1:0], st_ff.pair01[1:0]} & st_ff.filt_s;
    nxt_st.run = en_mask;
    nxt_st.gain_out = applied;
    nxt_st.ramp = ramping;
    // polarity flags follow the stored bit in the same edge as a write,
    // so the two views of one bit never disagree for a cycle
    nxt_st.neg_a = ~nxt_st.pair01[adc_path_pkg::bit_pol];
    nxt_st.neg_b = ~nxt_st.pair23[adc_path_pkg::bit_pol];
  end
  // register the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // registers clear, but the applied gain sits at full attenuation and
      // a zero polarity bit means a one is negative
      st_ff <= '0;
      st_ff.gain_out <= adc_path_pkg::gain_floor;
      st_ff.neg_a <= 1'b1;
      st_ff.neg_b <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign pair01_source_sel = st_ff.pair01[adc_path_pkg::bit_src];
  assign pair23_source_sel = st_ff.pair23[adc_path_pkg::bit_src];
  assign mic_pair_a_polarity = st_ff.pair01[adc_path_pkg::bit_pol];
  assign mic_pair_b_polarity = st_ff.pair23[adc_path_pkg::bit_pol];
  // polarity zero means a zero bit is positive, so a one is negative
  assign mic_a_one_negative = st_ff.neg_a;
  assign mic_b_one_negative = st_ff.neg_b;
  assign mic_pair_a_swap = st_ff.pair01[adc_path_pkg::bit_swap];
  assign mic_pair_b_swap = st_ff.pair23[adc_path_pkg::bit_swap];
  // channel taken on the rising edge: left unless swapped
  assign mic_a_rise_chan = {1'b0, st_ff.pair01[adc_path_pkg::bit_swap]};
  assign mic_b_rise_chan = {1'b0, st_ff.pair23[adc_path_pkg::bit_swap]};
  assign pair01_highpass_sel = st_ff.pair01[adc_path_pkg::bit_hp_hi:adc_path_pkg::bit_hp_lo];
  assign pair23_highpass_sel = st_ff.pair23[adc_path_pkg::bit_hp_hi:adc_path_pkg::bit_hp_lo];
  assign conv_running = st_ff.run;
  assign ch0_gain_code = st_ff.gain_out;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_run_needs_both: assert property (@(posedge pclk) disable iff (!presetn)
    conv_running[0] |-> $past(st_ff.pair01[0]) && $past(st_ff.filt_s[0]))
    else $error("converter running without both enables");
  a_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && paddr == adc_path_pkg::addr_pair01)
      |=> pair01_source_sel == $past(pwdata[2]))
    else $error("pair control write lost");
  a_polarity_map: assert property (@(posedge pclk) disable iff (!presetn)
    mic_a_one_negative != mic_pair_a_polarity)
    else $error("polarity mapping wrong");
  a_swap_edge: assert property (@(posedge pclk) disable iff (!presetn)
    mic_b_rise_chan[0] == mic_pair_b_swap)
    else $error("swap edge mapping wrong");
  a_hp_field: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && paddr == adc_path_pkg::addr_pair23)
      |=> pair23_highpass_sel == $past(pwdata[6:5]))
    else $error("high-pass field not stored");
  a_ready_one: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held two cycles");
  a_off_floor: assert property (@(posedge pclk) disable iff (!presetn)
    (!gain_bypass && !st_ff.filt_s[0] && $past(!st_ff.filt_s[0])) |=> ch0_gain_code == 8'hff)
    else $error("gain not at floor while filter off");
  a_gain_unity: assert property (@(posedge pclk) disable iff (!presetn)
    $past(gain_bypass) |-> ch0_gain_code == 8'h00)
    else $error("bypass not unity");
  a_polarity_map_b: assert property (@(posedge pclk) disable iff (!presetn)
    mic_b_one_negative != mic_pair_b_polarity)
    else $error("pair b polarity mapping wrong");
  a_swap_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    mic_a_rise_chan == {1'b0, mic_pair_a_swap})
    else $error("pair a swap edge mapping wrong");
  // bus answer: one wait state, error only on an unmapped address
  a_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("access not answered in the second cycle");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready) |-> pslverr == !hit)
    else $error("slave error does not follow the address decode");
  // read data: eight-bit registers leave the upper bits clear
  a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr != adc_path_pkg::addr_status)
      |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_gain_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !pwrite && paddr == adc_path_pkg::addr_gain0)
      |-> prdata[7:0] == st_ff.gain0)
    else $error("gain register read back wrong");
  // per converter: running is exactly enable bit and filter, a cycle late
  for (genvar c = 0; c < 4; c++) begin : g_run_chk
    a_run_each: assert property (@(posedge pclk) disable iff (!presetn)
      conv_running[c] == $past((c < 2 ? st_ff.pair01[c % 2] : st_ff.pair23[c % 2])
                               && st_ff.filt_s[c]))
      else $error("converter run state wrong");
  end
  c_err: cover property (@(posedge pclk) pslverr);
  c_dmic: cover property (@(posedge pclk) pair01_source_sel && pair23_source_sel);
  c_run: cover property (@(posedge pclk) conv_running == 4'hf);
  c_gain_bypass: cover property (@(posedge pclk) gain_bypass && ch0_gain_code == 8'h00);
endmodule : adc_path_control_regs

// [adc_path_control_regs_tb.sv]
// testbench: apb reads and writes of the capture path control bank,
// with the sample strobe, filter enables, mute and bypass driven here.
// assumes: the design package is compiled first; pready answers in time.
`timescale 1ns/1ps
module adc_path_control_regs_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0; // 20 MHz bus clock
  logic presetn = 1'b0; // async reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fs_tick = 1'b0; // sample strobe
  logic [3:0] decim_filter_on = 4'h0; // filter enables, normally from power ctrl
  logic [1:0] ch01_mute = 2'h0;
  logic gain_bypass = 1'b0;
  logic pair01_source_sel, pair23_source_sel, mic_pair_a_polarity, mic_pair_b_polarity;
  logic [1:0] mic_a_rise_chan, mic_b_rise_chan, pair01_highpass_sel, pair23_highpass_sel;
  logic mic_a_one_negative, mic_b_one_negative, mic_pair_a_swap, mic_pair_b_swap;
  logic [3:0] conv_running;
  logic [7:0] ch0_gain_code;
  int n_mismatch = 0; // mismatches seen
  int tests_run = 0; // comparisons made
  logic [31:0] rd; // last read data
  logic err; // last slave error
  logic [7:0] v; // pair value under test
  // clock: half period 25 ns
  always #25 pclk = ~pclk;
  adc_path_control_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fs_tick(fs_tick),
    .decim_filter_on(decim_filter_on), .ch01_mute(ch01_mute), .gain_bypass(gain_bypass),
    .pair01_source_sel(pair01_source_sel), .pair23_source_sel(pair23_source_sel),
    .mic_pair_a_polarity(mic_pair_a_polarity), .mic_pair_b_polarity(mic_pair_b_polarity),
    .mic_a_rise_chan(mic_a_rise_chan), .mic_b_rise_chan(mic_b_rise_chan),
    .mic_a_one_negative(mic_a_one_negative), .mic_b_one_negative(mic_b_one_negative),
    .mic_pair_a_swap(mic_pair_a_swap), .mic_pair_b_swap(mic_pair_b_swap),
    .pair01_highpass_sel(pair01_highpass_sel), .pair23_highpass_sel(pair23_highpass_sel),
    .conv_running(conv_running), .ch0_gain_code(ch0_gain_code));
  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  // compare and count; x on the design side never matches
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // n sample strobes, one cycle high with one cycle gap
  task ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      fs_tick <= 1'b1;
      @(posedge pclk);
      fs_tick <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : ticks
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(50 * 20000);
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and idle gain code
    apb(1'b0, adc_path_pkg::addr_pair01, 32'h0); chk(rd, 32'h0);
    apb(1'b0, adc_path_pkg::addr_pair23, 32'h0); chk(rd, 32'h0);
    apb(1'b0, adc_path_pkg::addr_gain0, 32'h0); chk(rd, 32'h0);
    chk(ch0_gain_code, adc_path_pkg::gain_floor);
    // every high-pass code, polarity, swap and source setting on both pairs
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, i[1:0], i[0], i[1], ~i[0], 2'b00};
      apb(1'b1, adc_path_pkg::addr_pair01, {24'h0, v});
      apb(1'b1, adc_path_pkg::addr_pair23, {24'h0, v ^ 8'h1c});
      apb(1'b0, adc_path_pkg::addr_pair01, 32'h0); chk(rd, {24'h0, v & 8'h7f});
      @(posedge pclk);
      chk(pair01_highpass_sel, i[1:0]);
      chk(pair23_highpass_sel, i[1:0]);
      chk({mic_pair_a_polarity, mic_a_one_negative}, {v[4], ~v[4]});
      chk({mic_pair_b_polarity, mic_b_one_negative}, {~v[4], v[4]});
      chk({mic_pair_a_swap, mic_a_rise_chan}, {v[3], 1'b0, v[3]});
      chk({mic_pair_b_swap, mic_b_rise_chan}, {~v[3], 1'b0, ~v[3]});
      chk({pair01_source_sel, pair23_source_sel}, {v[2], ~v[2]});
    end
    // unmapped address refused; status is read-only
    apb(1'b1, 12'h200, 32'hff); chk(err, 1'b1);
    apb(1'b0, 12'h200, 32'h0); chk(err, 1'b1);
    chk(rd, 32'h0);
    // converter runs only with enable bit and filter both set
    apb(1'b1, adc_path_pkg::addr_pair01, 32'h03);
    apb(1'b1, adc_path_pkg::addr_pair23, 32'h01);
    for (int f = 0; f < 16; f++) begin
      decim_filter_on <= f[3:0];
      repeat (3) @(posedge pclk);
      chk(conv_running, 4'b0111 & f[3:0]);
    end
    apb(1'b1, adc_path_pkg::addr_status, 32'h0);
    apb(1'b0, adc_path_pkg::addr_status, 32'h0); chk(rd[7:0], 8'h7f);
    // gain ramp from floor, one step per 16 strobes
    decim_filter_on <= 4'h0;
    apb(1'b1, adc_path_pkg::addr_gain0, 32'hfd);
    apb(1'b0, adc_path_pkg::addr_gain0, 32'h0); chk(rd, 32'hfd);
    decim_filter_on <= 4'h1;
    // let the filter enable reach the ramp before the first strobe counts
    repeat (3) @(posedge pclk);
    ticks(15); chk(ch0_gain_code, 8'hff);
    ticks(1); chk(ch0_gain_code, 8'hfe);
    apb(1'b0, adc_path_pkg::addr_status, 32'h0); chk(rd[16:8], {1'b1, 8'hfe});
    ticks(16); chk(ch0_gain_code, 8'hfd);
    ticks(16); chk(ch0_gain_code, 8'hfd);
    // mute walks toward full attenuation; bypass overrides mute
    ch01_mute <= 2'h1;
    ticks(16); chk(ch0_gain_code, 8'hfe);
    gain_bypass <= 1'b1;
    ticks(16); chk(ch0_gain_code, adc_path_pkg::gain_unity);
    gain_bypass <= 1'b0;
    ch01_mute <= 2'h0;
    // filter off then on restarts from the floor
    decim_filter_on <= 4'h0;
    repeat (3) @(posedge pclk);
    decim_filter_on <= 4'h1;
    repeat (3) @(posedge pclk);
    chk(ch0_gain_code, adc_path_pkg::gain_floor);
    // reset in mid-run brings the registers back to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adc_path_pkg::addr_pair01, 32'h0); chk(rd, 32'h0);
    apb(1'b0, adc_path_pkg::addr_gain0, 32'h0); chk(rd, 32'h0);
    chk(conv_running, 4'h0);
    chk(ch0_gain_code, adc_path_pkg::gain_floor);
    tally_and_finish();
  end
endmodule : adc_path_control_regs_tb
